// ===== pkg/flash_sp_pkg.sv
// shared constants and types for the flash self-programming controller
package flash_sp_pkg;

  // timing: system clock, write-timing oscillator, flash write window
  localparam int CLK_MHZ = 50;
  localparam int RC_MHZ = 1;
  localparam int T_MIN_US = 3700; // 3.7 ms
  localparam int T_MAX_US = 4500; // 4.5 ms
  localparam int MIN_CYC = T_MIN_US * CLK_MHZ;
  localparam int MAX_CYC = T_MAX_US * CLK_MHZ;
  localparam int RC_TICKS = T_MIN_US * RC_MHZ;
  localparam int CNT_W = 18;

  // address geometry
  localparam int PC_W = 13;
  localparam int PAGE_W = 7;
  localparam int WORD_W = 6;
  localparam int PTR_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [PC_W-1:0] STALL_REGION_START = 13'h1c00;
  localparam logic [PAGE_W-1:0] CONCURRENT_PAGES = 7'h70;

  // pointer field positions; bits 15:14 are never looked at
  localparam int Z_PC_HI = 13;
  localparam int Z_PAGE_LO = 7;
  localparam int Z_WORD_HI = 6;
  localparam int Z_WORD_LO = 1;
  localparam int Z_BYTE = 0;

  // boot section starts per size setting
  localparam logic [PC_W-1:0] BOOT_START_128 = 13'h1f80;
  localparam logic [PC_W-1:0] BOOT_START_256 = 13'h1f00;
  localparam logic [PC_W-1:0] BOOT_START_512 = 13'h1e00;
  localparam logic [PC_W-1:0] BOOT_START_1K = 13'h1c00;

  // register map and control bit positions
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CFG_OFS = 4'h4;
  localparam int EN_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam int REEN_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [4:0] CTRL_FILL = 5'h01;
  localparam logic [1:0] WIN_LOAD = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } state_e_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic spm;
    logic lpm;
    logic [PTR_W-1:0] ptr;
    logic [15:0] data;
  } spm_req_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic fill;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] word;
    logic [15:0] data;
  } flash_cmd_t;

  function automatic logic [PC_W-1:0] boot_start(input logic [1:0] sel);
    unique case (sel)
      2'h3: boot_start = BOOT_START_128;
      2'h2: boot_start = BOOT_START_256;
      2'h1: boot_start = BOOT_START_512;
      2'h0: boot_start = BOOT_START_1K;
    endcase
  endfunction : boot_start

  function automatic logic in_concurrent_region(input logic [PC_W-1:0] addr);
    in_concurrent_region = addr < STALL_REGION_START;
  endfunction : in_concurrent_region

endpackage : flash_sp_pkg

// ===== logic/flash_sp_timer.sv
// flash write timer paced by the internal rc oscillator
`timescale 1ns/10ps
module flash_sp_timer #(
  parameter int MIN_CYCLES = flash_sp_pkg::MIN_CYC,
  parameter int MAX_CYCLES = flash_sp_pkg::MAX_CYC,
  parameter int RC_COUNT = flash_sp_pkg::RC_TICKS
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_rc_osc,
  input wire logic i_start,
  output logic o_done
);
  import flash_sp_pkg::*;

  localparam logic [CNT_W-1:0] MIN_T = CNT_W'(MIN_CYCLES - 1);
  localparam logic [CNT_W-1:0] MAX_T = CNT_W'(MAX_CYCLES - 1);
  localparam logic [CNT_W-1:0] RC_T = CNT_W'(RC_COUNT);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic busy;
    logic done;
    logic [CNT_W-1:0] cyc;
    logic [CNT_W-1:0] ticks;
  } tmr_t;

  tmr_t s;
  tmr_t next_s;

  // rc edges pace the write; the mclk count only bounds it on both sides,
  // so a drifting oscillator can never stretch the write past the maximum
  always_comb begin
    next_s = s;
    next_s.s1 = i_rc_osc;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.done = 1'b0;
    if (i_start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cyc = '0;
      next_s.ticks = '0;
    end else if (s.busy) begin
      next_s.cyc = s.cyc + 1'b1;
      if (s.s2 && !s.s3) begin
        next_s.ticks = s.ticks + 1'b1; // R1
      end
      if ((s.ticks >= RC_T && s.cyc >= MIN_T) || s.cyc >= MAX_T) begin
        next_s.busy = 1'b0; // R2
        next_s.done = 1'b1;
      end
    end
  end

  // synchronous reset; clears the rc synchroniser as well
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_done = s.done;

  a_rc_paced: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R1
    s.done |-> (s.ticks >= RC_T && s.cyc > MIN_T) || s.cyc > MAX_T)
    else $error("write ended before rc count or bound");

endmodule : flash_sp_timer

// ===== logic/flash_self_program.sv
// self-programming sequencer: control register, pointer decode, region guard
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// R1 - flash write durations are paced by the internal rc oscillator
// R2 - erase, page write and lock write last 3.7 ms to 4.5 ms
// R3 - two-bit size setting picks 128/256/512/1024-word boot section at top
// R4 - boot vector is boot section start; application ends one word below
// R5 - concurrent-read region pages 0..111; stall-read words 0x1c00..0x1fff
// R6 - during erase or write only stall-read region code can be fetched
// R7 - program counter is 13 bits wide
// R8 - a page holds 64 words, selected by the six low word bits
// R9 - pointer bits sit one above word bits; pointer bit 13 is top
// R10 - erase and write take the page from pointer bits 13..7
// R11 - pointer bits 6..1 pick buffer word; zero them for page write
// R12 - pointer bits 15..14 are ignored everywhere
// R13 - pointer bit 0 zero for stores; byte select for loads
// R14 - software polls enable bit clear before a new operation
// R15 - software waits for eeprom write idle before control write
// R16 - concurrent-read region unreadable until re-enable command clears busy
// R17 - software masks interrupts around the timed control write
// R18 - store must follow control write within four cycles or is dropped
// R19 - busy flag stays set while the concurrent-read region is occupied
// R20 - boot size setting sampled at reset and held afterwards
module flash_self_program #(
  parameter int MIN_CYCLES = flash_sp_pkg::MIN_CYC,
  parameter int MAX_CYCLES = flash_sp_pkg::MAX_CYC,
  parameter int RC_COUNT = flash_sp_pkg::RC_TICKS
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_rc_osc,
  input wire logic [1:0] i_boot_size_fuse,
  input wire logic i_eeprom_busy,
  input wire flash_sp_pkg::reg_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire flash_sp_pkg::spm_req_t i_spm,
  output flash_sp_pkg::flash_cmd_t o_flash,
  output logic [flash_sp_pkg::PC_W-1:0] o_lpm_addr,
  output logic o_lpm_hi,
  input wire logic [flash_sp_pkg::PC_W-1:0] i_fetch_addr,
  output logic o_fetch_ok,
  output logic o_rw_busy,
  output logic o_spm_en,
  output logic [flash_sp_pkg::PC_W-1:0] o_boot_vector,
  output logic [flash_sp_pkg::PC_W-1:0] o_app_end
);
  import flash_sp_pkg::*;

  typedef struct packed {
    state_e_t st;
    logic [1:0] win;
    logic [4:0] ctrl;
    logic rw_busy;
    logic [1:0] fuse_s1;
    logic [1:0] fuse_s2;
    logic [1:0] boot_sel;
    flash_cmd_t cmd;
    logic [7:0] rdata;
    logic [PC_W-1:0] lpm_addr;
    logic lpm_hi;
  } top_t;

  localparam top_t TOP_RESET = '{
    st: ST_IDLE,
    win: 2'h0,
    ctrl: CTRL_RESET,
    rw_busy: 1'b0,
    fuse_s1: 2'h0,
    fuse_s2: 2'h0,
    boot_sel: 2'h0,
    cmd: '0,
    rdata: 8'h00,
    lpm_addr: '0,
    lpm_hi: 1'b0
  };

  top_t s;
  top_t next_s;
  logic tmr_start;
  logic tmr_done;
  logic [PAGE_W-1:0] z_page;
  logic flash_writing;

  // page select taken from pointer bits 13..7, bits 15..14 dropped
  assign z_page = i_spm.ptr[Z_PC_HI:Z_PAGE_LO]; // R10 R12

  flash_sp_timer #(
    .MIN_CYCLES(MIN_CYCLES),
    .MAX_CYCLES(MAX_CYCLES),
    .RC_COUNT(RC_COUNT)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_rc_osc(i_rc_osc),
    .i_start(tmr_start),
    .o_done(tmr_done)
  );

  // whole sequencer: register reads, arm window, command decode
  always_comb begin
    next_s = s;
    tmr_start = 1'b0;
    next_s.fuse_s1 = i_boot_size_fuse;
    next_s.fuse_s2 = s.fuse_s1;
    next_s.cmd.erase = 1'b0;
    next_s.cmd.write = 1'b0;
    next_s.cmd.lock = 1'b0;
    next_s.cmd.fill = 1'b0;
    next_s.rdata = 8'h00;
    // read data valid the cycle after the strobe; unmapped reads give zero
    if (i_bus.rd) begin
      if (i_bus.addr == CTRL_OFS) begin
        next_s.rdata = {1'b0, s.rw_busy, 1'b0, s.ctrl}; // R19
      end else if (i_bus.addr == CFG_OFS) begin
        next_s.rdata = {6'h00, s.boot_sel}; // R3
      end
    end
    // loads: word address from bits 13..1, byte lane from bit 0
    if (i_spm.lpm) begin
      next_s.lpm_addr = i_spm.ptr[Z_PC_HI:Z_WORD_LO]; // R7 R9 R12
      next_s.lpm_hi = i_spm.ptr[Z_BYTE]; // R13
    end
    unique case (s.st)
      ST_IDLE: begin
        // an eeprom write in progress locks the control register out
        if (i_bus.wr && i_bus.addr == CTRL_OFS && !i_eeprom_busy) begin // R15
          if (i_bus.wdata[EN_BIT]) begin
            next_s.ctrl = i_bus.wdata[4:0];
            next_s.st = ST_ARMED;
            next_s.win = WIN_LOAD; // R18
          end
        end
      end
      ST_ARMED: begin
        if (i_spm.spm) begin
          next_s.ctrl = CTRL_RESET;
          next_s.st = ST_IDLE;
          if (s.ctrl[ERASE_BIT] || s.ctrl[WRITE_BIT]) begin
            // enable stays set until the timed write finishes
            tmr_start = 1'b1;
            next_s.st = ST_BUSY;
            next_s.ctrl = s.ctrl; // R14
            next_s.cmd.erase = s.ctrl[ERASE_BIT];
            next_s.cmd.write = !s.ctrl[ERASE_BIT];
            next_s.cmd.page = z_page; // R10
            next_s.cmd.word = '0; // R11
            if (z_page < CONCURRENT_PAGES) begin
              next_s.rw_busy = 1'b1; // R5 R19
            end
          end else if (s.ctrl[LOCK_BIT]) begin
            // lock writes leave the whole flash readable
            tmr_start = 1'b1;
            next_s.st = ST_BUSY;
            next_s.ctrl = s.ctrl;
            next_s.cmd.lock = 1'b1;
            next_s.cmd.data = i_spm.data;
          end else if (s.ctrl[REEN_BIT]) begin
            next_s.rw_busy = 1'b0; // R16
          end else if (s.ctrl == CTRL_FILL) begin
            next_s.cmd.fill = 1'b1;
            next_s.cmd.word = i_spm.ptr[Z_WORD_HI:Z_WORD_LO]; // R8 R11
            next_s.cmd.data = i_spm.data;
          end
        end else if (s.win == 2'h0) begin
          // store came too late: the request silently lapses
          next_s.ctrl = CTRL_RESET; // R18
          next_s.st = ST_IDLE;
        end else begin
          next_s.win = s.win - 1'b1;
        end
      end
      ST_BUSY: begin
        // writes to the control register are ignored until done
        if (tmr_done) begin
          next_s.ctrl = CTRL_RESET; // R2 R14
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.ctrl = CTRL_RESET;
      end
    endcase
  end

  // boot size is caught while reset is held, then frozen
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s <= TOP_RESET;
      s.fuse_s1 <= i_boot_size_fuse;
      s.fuse_s2 <= s.fuse_s1;
      s.boot_sel <= s.fuse_s2; // R20
    end else begin
      s <= next_s;
    end
  end

  // outputs; vector is a pure decode of the frozen size setting
  assign o_rdata = s.rdata;
  assign o_flash = s.cmd;
  assign o_lpm_addr = s.lpm_addr;
  assign o_lpm_hi = s.lpm_hi;
  assign o_rw_busy = s.rw_busy;
  assign o_spm_en = s.ctrl[EN_BIT];
  assign o_boot_vector = boot_start(s.boot_sel); // R3 R4
  assign o_app_end = boot_start(s.boot_sel) - 1'b1; // R4
  // fetches below the stall-read boundary wait while busy is up; an erase
  // or page write holds them off too even when its page lies above the
  // boundary, since the array cannot serve reads while it is written
  assign flash_writing = s.st == ST_BUSY &&
    (s.ctrl[ERASE_BIT] || s.ctrl[WRITE_BIT]); // R6
  assign o_fetch_ok = !((s.rw_busy || flash_writing) &&
    in_concurrent_region(i_fetch_addr)); // R6 R16

  // checks: one clock, all quiet while reset is held
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  int op_cyc;
  // helper: counts cycles spent in the timed write
  always_ff @(posedge i_mclk) begin
    if (!i_nrst || s.st != ST_BUSY) begin
      op_cyc <= 0;
    end else begin
      op_cyc <= op_cyc + 1;
    end
  end

  sequence armed_no_store;
    $rose(s.st == ST_ARMED) ##0 (!i_spm.spm)[*4];
  endsequence

  sequence erase_write_store;
    s.st == ST_ARMED && i_spm.spm &&
      (s.ctrl[ERASE_BIT] || s.ctrl[WRITE_BIT]);
  endsequence

  a_store_window: assert property ( // R18
    armed_no_store |=> s.st == ST_IDLE && !o_spm_en)
    else $error("late store did not lapse");

  a_op_duration: assert property ( // R2
    $fell(s.st == ST_BUSY) |-> op_cyc >= MIN_CYCLES &&
      op_cyc <= MAX_CYCLES + 1)
    else $error("timed write outside allowed duration");

  a_page_select: assert property ( // R10
    erase_write_store |=> (o_flash.erase || o_flash.write) &&
      o_flash.page == $past(i_spm.ptr[13:7]))
    else $error("page select not from pointer bits 13..7");

  a_busy_mark: assert property ( // R5
    erase_write_store |=> o_rw_busy == ($past(i_spm.ptr[13:7]) < 7'h70 ||
      $past(s.rw_busy)))
    else $error("region busy flag set for wrong page");

  a_fill_word: assert property ( // R11 R8
    s.st == ST_ARMED && i_spm.spm && s.ctrl == CTRL_FILL
      |=> o_flash.fill && o_flash.word == $past(i_spm.ptr[6:1]))
    else $error("buffer word not from pointer bits 6..1");

  a_load_map: assert property ( // R13 R12 R9
    i_spm.lpm |=> o_lpm_hi == $past(i_spm.ptr[0]) &&
      o_lpm_addr == $past(i_spm.ptr[13:1]))
    else $error("load address or byte lane mismapped");

  a_fetch_block: assert property ( // R6
    o_rw_busy && i_fetch_addr < 13'h1c00 |-> !o_fetch_ok)
    else $error("low region fetch allowed while busy");

  a_write_stall: assert property ( // R6
    s.st == ST_BUSY && (s.ctrl[ERASE_BIT] || s.ctrl[WRITE_BIT]) &&
      i_fetch_addr < 13'h1c00 |-> !o_fetch_ok)
    else $error("fetch allowed below boundary during erase or write");

  a_busy_hold: assert property ( // R19
    o_rw_busy && s.st == ST_BUSY |=> o_rw_busy [*2])
    else $error("region busy dropped without re-enable");

  a_reenable: assert property ( // R16
    s.st == ST_ARMED && i_spm.spm && s.ctrl[REEN_BIT] &&
      !s.ctrl[ERASE_BIT] && !s.ctrl[WRITE_BIT] && !s.ctrl[LOCK_BIT]
      |=> !o_rw_busy ##1 o_fetch_ok)
    else $error("re-enable did not free the low region");

  a_boot_layout: assert property ( // R3 R4
    o_app_end + 13'h0001 == o_boot_vector &&
      (s.boot_sel != 2'h0 || o_boot_vector == 13'h1c00) &&
      (s.boot_sel != 2'h3 || o_boot_vector == 13'h1f80))
    else $error("boot vector or application end wrong");

  a_boot_frozen: assert property ( // R20
    $past(i_nrst) |-> $stable(s.boot_sel))
    else $error("boot size changed after reset");

  a_refused_arm: assert property ( // R15
    s.st == ST_IDLE && i_bus.wr && i_eeprom_busy |=> !o_spm_en)
    else $error("control write taken while eeprom write busy");

  a_busy_readback: assert property ( // R19
    i_bus.rd && i_bus.addr == CTRL_OFS |=> o_rdata[6] == $past(o_rw_busy))
    else $error("busy flag read back wrong");

endmodule : flash_self_program

// ===== sim/boot_cpu_model.sv
// boot loader cpu model driving the control register and store ports
`timescale 1ns/10ps
module boot_cpu_model (
  input wire logic i_mclk,
  input wire logic i_eeprom_busy,
  input wire logic [7:0] i_rdata,
  output flash_sp_pkg::reg_req_t o_bus,
  output flash_sp_pkg::spm_req_t o_spm
);
  import flash_sp_pkg::*;
  // idle strobes from time zero so nothing unknown reaches the sequencer
  initial begin
    o_bus = '0;
    o_spm = '0;
  end
  // one-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_bus.addr <= a;
    o_bus.wdata <= d;
    o_bus.wr <= 1'b1;
    @(posedge i_mclk);
    o_bus.wr <= 1'b0;
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_bus.addr <= a;
    o_bus.rd <= 1'b1;
    @(posedge i_mclk);
    o_bus.rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : reg_rd
  // store strobe; a lapse of 3 or more misses the armed window
  task automatic store(input int lapse, input logic [15:0] p,
                       input logic [15:0] d);
    repeat (lapse) @(posedge i_mclk);
    @(posedge i_mclk);
    o_spm.ptr <= p;
    o_spm.data <= d;
    o_spm.spm <= 1'b1;
    @(posedge i_mclk);
    o_spm.spm <= 1'b0;
  endtask : store
  // program-memory load strobe
  task automatic load(input logic [15:0] p);
    @(posedge i_mclk);
    o_spm.ptr <= p;
    o_spm.lpm <= 1'b1;
    @(posedge i_mclk);
    o_spm.lpm <= 1'b0;
  endtask : load
  // whole timed sequence as boot software runs it
  task automatic do_spm(input logic [7:0] c, input logic [15:0] p,
                        input logic [15:0] d);
    logic [7:0] r;
    int n;
    r = 8'h01;
    n = 0;
    while (r[EN_BIT] && n < 200) begin
      reg_rd(CTRL_OFS, r);
      n++;
    end
    while (i_eeprom_busy) @(posedge i_mclk);
    // no interrupts modelled, so nothing splits write and store
    reg_wr(CTRL_OFS, c);
    store(0, p, d);
  endtask : do_spm
endmodule : boot_cpu_model

// ===== sim/test_flash_self_program.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
  end end
module test_flash_self_program;
  import flash_sp_pkg::*;
  // short timed write so the run stays brief
  localparam int T_MIN = 20;
  localparam int T_MAX = 40;
  logic mclk, nrst, rc_osc, rc_run, ee_busy, lpm_hi, fetch_ok;
  logic rw_busy, spm_en;
  logic [1:0] fuse;
  logic [7:0] rdata, rd;
  logic [PC_W-1:0] fetch_addr, lpm_addr, boot_vec, app_end, exp_start;
  reg_req_t bus;
  spm_req_t spm;
  flash_cmd_t flash;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  flash_self_program #(.MIN_CYCLES(T_MIN), .MAX_CYCLES(T_MAX),
    .RC_COUNT(3)) i_dut (
    .i_mclk(mclk),
    .i_nrst(nrst),
    .i_rc_osc(rc_osc),
    .i_boot_size_fuse(fuse),
    .i_eeprom_busy(ee_busy),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_spm(spm),
    .o_flash(flash),
    .o_lpm_addr(lpm_addr),
    .o_lpm_hi(lpm_hi),
    .i_fetch_addr(fetch_addr),
    .o_fetch_ok(fetch_ok),
    .o_rw_busy(rw_busy),
    .o_spm_en(spm_en),
    .o_boot_vector(boot_vec),
    .o_app_end(app_end)
  );
  boot_cpu_model i_cpu (
    .i_mclk(mclk),
    .i_eeprom_busy(ee_busy),
    .i_rdata(rdata),
    .o_bus(bus),
    .o_spm(spm)
  );
  // system clock, 20 ns
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // rc oscillator, unrelated in phase; can be stopped to starve the timer
  initial begin
    rc_osc = 1'b0;
    forever #37 if (rc_run) rc_osc = ~rc_osc;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic [1:0] code);
    @(posedge mclk);
    nrst <= 1'b0;
    fuse <= code;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset
  task automatic fetch(input logic [12:0] a, input logic e);
    @(posedge mclk);
    fetch_addr <= a;
    #1;
    `CHK(fetch_ok, e)
  endtask : fetch
  // bounded wait for the enable bit to drop, counting edges
  task automatic wait_idle(output int c);
    c = 0;
    while (spm_en === 1'b1 && c < 1000) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : wait_idle
  // watchdog: tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    rc_run = 1'b1;
    ee_busy = 1'b0;
    fuse = 2'h3;
    fetch_addr = '0;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1:0]);
      @(posedge mclk);
      fuse <= ~k[1:0]; // a later change must not move the boot section
      repeat (4) @(posedge mclk);
      #1;
      exp_start = 13'h1fff - (13'h80 << (3 - k)) + 13'h1;
      `CHK(boot_vec, exp_start)
      `CHK(app_end, exp_start - 13'h1)
      i_cpu.reg_rd(CFG_OFS, rd);
      `CHK(rd[1:0], k[1:0])
    end
    `CHK({spm_en, rw_busy, fetch_ok}, 3'b001)
    i_cpu.reg_wr(4'h8, 8'hff);
    i_cpu.reg_rd(4'h8, rd);
    `CHK(rd, 8'h00)
    $display("test boot sizes done");
    // buffer fill with ignored top pointer bits, then loads
    i_cpu.do_spm(8'h01, 16'hc006, 16'habcd);
    #1;
    `CHK({flash.fill, flash.word, flash.data}, {1'b1, 6'h03, 16'habcd})
    `CHK(spm_en, 1'b0)
    i_cpu.reg_wr(CTRL_OFS, 8'h01);
    i_cpu.store(2, 16'h007e, 16'h5a5a);
    #1;
    `CHK({flash.fill, flash.word}, {1'b1, 6'h3f})
    i_cpu.reg_wr(CTRL_OFS, 8'h01);
    i_cpu.store(3, 16'h0002, 16'h1234);
    #1;
    `CHK({flash.fill, flash.data, spm_en}, {1'b0, 16'h5a5a, 1'b0})
    i_cpu.load(16'hc003);
    #1;
    `CHK({lpm_addr, lpm_hi}, {13'h0001, 1'b1})
    i_cpu.load(16'h3ffe);
    #1;
    `CHK({lpm_addr, lpm_hi}, {13'h1fff, 1'b0})
    $display("test fill and load done");
    // refused control writes
    @(posedge mclk);
    ee_busy <= 1'b1;
    i_cpu.reg_wr(CTRL_OFS, 8'h01);
    @(posedge mclk);
    ee_busy <= 1'b0;
    #1;
    `CHK(spm_en, 1'b0)
    i_cpu.reg_wr(CTRL_OFS, 8'h02);
    @(posedge mclk);
    #1;
    `CHK(spm_en, 1'b0)
    $display("test refusals done");
    // erase of a low page, region blocked until re-enable
    i_cpu.do_spm(8'h03, 16'hcf80, 16'h0000);
    #1;
    `CHK({flash.erase, flash.page, flash.word}, {1'b1, 7'h1f, 6'h00})
    `CHK(rw_busy, 1'b1)
    wait_idle(n);
    `CHK(n >= T_MIN && n <= T_MIN + 4, 1'b1)
    fetch(13'h1bff, 1'b0);
    fetch(13'h1c00, 1'b1);
    i_cpu.reg_rd(CTRL_OFS, rd);
    `CHK({rd[6], rd[0]}, 2'b10)
    i_cpu.do_spm(8'h11, 16'h0000, 16'h0000);
    #1;
    `CHK(rw_busy, 1'b0)
    fetch(13'h0000, 1'b1);
    $display("test erase done");
    // page write in a top page with the rc stopped: only the ceiling ends it
    @(posedge mclk);
    rc_run <= 1'b0;
    i_cpu.do_spm(8'h05, 16'h3f80, 16'h0000);
    #1;
    `CHK({flash.write, flash.page, rw_busy}, {1'b1, 7'h7f, 1'b0})
    fetch(13'h0000, 1'b0);
    wait_idle(n);
    `CHK(n >= T_MAX - 1 && n <= T_MAX + 2, 1'b1)
    rc_run <= 1'b1;
    $display("test page write done");
    // lock write; a control write while busy is ignored
    i_cpu.do_spm(8'h09, 16'h0001, 16'h00ff);
    #1;
    `CHK({flash.lock, flash.data, rw_busy}, {1'b1, 16'h00ff, 1'b0})
    i_cpu.reg_wr(CTRL_OFS, 8'h03);
    i_cpu.store(0, 16'h0080, 16'h0000);
    #1;
    `CHK(flash.erase, 1'b0)
    fetch(13'h0000, 1'b1);
    wait_idle(n);
    `CHK(n >= T_MIN - 6 && n <= T_MIN + 4, 1'b1)
    $display("test lock write done");
    give_verdict();
  end
endmodule : test_flash_self_program
